/* design/ldcr_regs.svh */
`ifndef LDCR_REGS_SVH
`define LDCR_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define LDCR_AUX2_CTRL_OFS   8'h28
`define LDCR_AUX3_CTRL_OFS   8'h29
`define LDCR_DIS_FIRST_OFS   8'h40
`define LDCR_DIS_SECOND_OFS  8'h41

// ****************************************************************
// reset values
// ****************************************************************
`define LDCR_AUX2_CTRL_RST   8'h0c
`define LDCR_AUX3_CTRL_RST   8'h3c
`define LDCR_DIS_FIRST_RST   8'h55
`define LDCR_DIS_SECOND_RST  8'h55

// ****************************************************************
// aux control field layout
// ****************************************************************
`define LDCR_SLP_EN_HI       5
`define LDCR_SLP_EN_LO       4
`define LDCR_RSV_HI          3
`define LDCR_RSV_LO          1
`define LDCR_PERMIT_BIT      0
`define LDCR_RSV_NOMINAL     3'h6
`define LDCR_STORED_W        6

// ****************************************************************
// discharge field layout
// ****************************************************************
`define LDCR_DIS_FIELD_W     2
`define LDCR_DIS_FIELDS      8

`endif

/* design/ldcr_pkg.sv */
`default_nettype none
package ldcr_pkg;

  // discharge resistance selection per rail
  typedef enum logic [1:0] {
    LDCR_DIS_NONE = 2'h0,
    LDCR_DIS_100R = 2'h1,
    LDCR_DIS_200R = 2'h2,
    LDCR_DIS_500R = 2'h3
  } ldcr_dis_t;

endpackage : ldcr_pkg
`default_nettype wire

/* design/ldcr_aux_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ldcr_regs.svh"

module ldcr_aux_ctrl #(
  parameter logic [7:0] RST_VAL = `LDCR_AUX2_CTRL_RST
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_on_request,
  input  wire logic       i_sleep_pin,
  output logic      [7:0] o_reg,
  output logic            o_enable,
  output logic            o_sleep,
  output logic            o_codes_ignored
);

  logic [`LDCR_STORED_W-1:0] ctrl_ff;
  logic                      enable_ff;
  logic                      sleep_ff;
  logic                      ignored_ff;

  // ****************************************************************
  // register storage
  // ****************************************************************
  // top two bits are not stored at all, so writes there are lost
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_ff <= RST_VAL[`LDCR_STORED_W-1:0]; // RL1 RL2 RL3 RL4 RL8 RL9
    end else if (i_wr_en) begin
      ctrl_ff <= i_wdata[`LDCR_STORED_W-1:0]; // RL14
    end
  end

  assign o_reg = {2'h0, ctrl_ff}; // RL14

  // ****************************************************************
  // regulator control
  // ****************************************************************
  // permit bit low overrides any pin request
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      enable_ff <= 1'b0;
    end else begin
      enable_ff <= ctrl_ff[`LDCR_PERMIT_BIT] & i_on_request; // RL8 RL9
    end
  end

  // any nonzero sleep code enables pin-driven sleep voltage
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sleep_ff <= 1'b0;
    end else begin
      sleep_ff <= (|ctrl_ff[`LDCR_SLP_EN_HI:`LDCR_SLP_EN_LO]) // RL3 RL4
                  & i_sleep_pin; // RL5
    end
  end

  // lower reserved codes leave voltage codes unused
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ignored_ff <= 1'b0;
    end else begin
      ignored_ff <= ctrl_ff[`LDCR_RSV_HI:`LDCR_RSV_LO]
                    < `LDCR_RSV_NOMINAL; // RL6 RL7
    end
  end

  assign o_enable        = enable_ff;
  assign o_sleep         = sleep_ff;
  assign o_codes_ignored = ignored_ff;

endmodule : ldcr_aux_ctrl

`default_nettype wire

/* design/ldcr_top.sv */
// Notes on behaviour
// RL1: aux2 control at 28h, resets 0ch
// RL2: aux3 control at 29h, resets 3ch
// RL3: aux2 sleep code zero disables, resets zero
// RL4: aux3 sleep code same, resets to 3h
// RL5: sleep voltage follows factory-chosen select pin
// RL6: software keeps aux2 reserved field at 6h
// RL7: software keeps aux3 reserved field at 6h
// RL8: aux2 permit bit zero forces regulator off
// RL9: aux3 permit bit zero forces regulator off
// RL10: first discharge register 40h, four fields, 55h
// RL11: second discharge register 41h, four fields, 55h
// RL12: discharge codes: none, 100, 200, 500 ohm
// RL13: enabled rail clears its discharge field
// RL14: aux control bits 7-6 read zero
// RL15: byte registers accessed by offset
`timescale 1ns/1ps
`default_nettype none
`include "ldcr_regs.svh"

module ldcr_top (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr_en,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_rd_en,
  input  wire logic [7:0]  i_rail_on,
  input  wire logic        i_aux2_on_request,
  input  wire logic        i_aux3_on_request,
  input  wire logic        i_sleep_select_pin_a,
  input  wire logic        i_sleep_select_pin_b,
  input  wire logic        i_aux2_sleep_use_pin_b,
  input  wire logic        i_aux3_sleep_use_pin_b,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_aux2_enable,
  output logic             o_aux3_enable,
  output logic             o_aux2_sleep,
  output logic             o_aux3_sleep,
  output logic             o_aux2_codes_ignored,
  output logic             o_aux3_codes_ignored,
  output logic      [15:0] o_discharge_select,
  output logic      [7:0]  o_discharge_active
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic ldcr_pkg::ldcr_dis_t dis_field(
    input logic [15:0] sel,
    input int          idx
  );
    dis_field = ldcr_pkg::ldcr_dis_t'(sel[idx*`LDCR_DIS_FIELD_W +: 2]);
  endfunction : dis_field

  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    hit = (addr == ofs); // RL15
  endfunction : hit

  // ****************************************************************
  // aux regulator control
  // ****************************************************************
  logic [7:0] aux2_reg;
  logic [7:0] aux3_reg;
  logic       aux2_sleep_pin;
  logic       aux3_sleep_pin;

  // pin choice is a factory strap, never a register field
  assign aux2_sleep_pin = i_aux2_sleep_use_pin_b ? i_sleep_select_pin_b
                                                 : i_sleep_select_pin_a; // RL5
  assign aux3_sleep_pin = i_aux3_sleep_use_pin_b ? i_sleep_select_pin_b
                                                 : i_sleep_select_pin_a; // RL5

  ldcr_aux_ctrl #(
    .RST_VAL (`LDCR_AUX2_CTRL_RST)
  ) u_aux2 (
    .i_clk           (i_clk),
    .i_sys_rst       (i_sys_rst),
    .i_wr_en         (i_reg_wr_en & hit(i_reg_addr, `LDCR_AUX2_CTRL_OFS)), // RL1
    .i_wdata         (i_reg_wdata),
    .i_on_request    (i_aux2_on_request),
    .i_sleep_pin     (aux2_sleep_pin),
    .o_reg           (aux2_reg),
    .o_enable        (o_aux2_enable),
    .o_sleep         (o_aux2_sleep),
    .o_codes_ignored (o_aux2_codes_ignored)
  );

  ldcr_aux_ctrl #(
    .RST_VAL (`LDCR_AUX3_CTRL_RST)
  ) u_aux3 (
    .i_clk           (i_clk),
    .i_sys_rst       (i_sys_rst),
    .i_wr_en         (i_reg_wr_en & hit(i_reg_addr, `LDCR_AUX3_CTRL_OFS)), // RL2
    .i_wdata         (i_reg_wdata),
    .i_on_request    (i_aux3_on_request),
    .i_sleep_pin     (aux3_sleep_pin),
    .o_reg           (aux3_reg),
    .o_enable        (o_aux3_enable),
    .o_sleep         (o_aux3_sleep),
    .o_codes_ignored (o_aux3_codes_ignored)
  );

  // ****************************************************************
  // discharge control
  // ****************************************************************
  // low byte is the first register, high byte the second
  logic [15:0] dis_ff;
  logic [15:0] nxt_dis;
  logic [15:0] dis_clear_mask;
  logic [7:0]  active_ff;

  always_comb begin
    nxt_dis = dis_ff;
    if (i_reg_wr_en && hit(i_reg_addr, `LDCR_DIS_FIRST_OFS)) begin
      nxt_dis[7:0] = i_reg_wdata; // RL10
    end
    if (i_reg_wr_en && hit(i_reg_addr, `LDCR_DIS_SECOND_OFS)) begin
      nxt_dis[15:8] = i_reg_wdata; // RL11
    end
    for (int k = 0; k < `LDCR_DIS_FIELDS; k++) begin
      dis_clear_mask[k*2 +: 2] = {2{i_rail_on[k]}};
    end
    // clear beats a same-cycle write: a running rail never discharges
    nxt_dis = nxt_dis & ~dis_clear_mask; // RL13
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dis_ff <= {`LDCR_DIS_SECOND_RST, `LDCR_DIS_FIRST_RST}; // RL10 RL11
    end else begin
      dis_ff <= nxt_dis;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      active_ff <= 8'h00;
    end else begin
      for (int k = 0; k < `LDCR_DIS_FIELDS; k++) begin
        active_ff[k] <= dis_field(nxt_dis, k)
                        != ldcr_pkg::LDCR_DIS_NONE; // RL12
      end
    end
  end

  assign o_discharge_select = dis_ff;
  assign o_discharge_active = active_ff;

  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped offsets return zero; data held until next read
  logic [7:0] rdata_ff;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_ff <= 8'h00;
    end else if (i_reg_rd_en) begin
      case (i_reg_addr)
        `LDCR_AUX2_CTRL_OFS:  rdata_ff <= aux2_reg; // RL14
        `LDCR_AUX3_CTRL_OFS:  rdata_ff <= aux3_reg; // RL14
        `LDCR_DIS_FIRST_OFS:  rdata_ff <= dis_ff[7:0];
        `LDCR_DIS_SECOND_OFS: rdata_ff <= dis_ff[15:8];
        default:              rdata_ff <= 8'h00;
      endcase
    end
  end

  assign o_reg_rdata = rdata_ff;

endmodule : ldcr_top

`default_nettype wire

/* testbench/ldcr_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ldcr_chk (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_wr_en,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_rd_en,
  input wire logic [7:0]  i_rail_on,
  input wire logic        i_aux3_on_request,
  input wire logic        i_sleep_select_pin_a,
  input wire logic        i_sleep_select_pin_b,
  input wire logic        i_aux2_sleep_use_pin_b,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        o_aux2_enable,
  input wire logic        o_aux3_enable,
  input wire logic        o_aux2_sleep,
  input wire logic [15:0] o_discharge_select,
  input wire logic [7:0]  o_discharge_active
);
  // ****
  // port relations
  // ****
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_wr2; i_reg_wr_en && i_reg_addr == 8'h28; endsequence
  sequence s_wr3; i_reg_wr_en && i_reg_addr == 8'h29; endsequence
  sequence s_rd(a); i_reg_rd_en && i_reg_addr == a; endsequence
  // enable lags the register by one more edge
  chk_aux2_forced_off: assert property (s_wr2 ##0 !i_reg_wdata[0]
    |-> ##2 !o_aux2_enable) else $error("aux2 on while barred");
  chk_aux3_forced_off: assert property (s_wr3 ##0 !i_reg_wdata[0]
    |-> ##2 !o_aux3_enable) else $error("aux3 on while barred");
  chk_aux2_no_sleep: assert property (s_wr2 ##0 !(|i_reg_wdata[5:4])
    |-> ##2 !o_aux2_sleep) else $error("aux2 sleeps with code 0");
  chk_aux3_needs_req: assert property (o_aux3_enable
    |-> $past(i_aux3_on_request)) else $error("aux3 on without request");
  chk_sleep_pin_sel: assert property (o_aux2_sleep |-> $past(
    i_aux2_sleep_use_pin_b ? i_sleep_select_pin_b : i_sleep_select_pin_a))
    else $error("aux2 sleep without its pin");
  chk_top_bits_zero: assert property ((s_rd(8'h28) or s_rd(8'h29))
    |=> o_reg_rdata[7:6] == 2'h0) else $error("aux top bits set");
  chk_unmapped_zero: assert property (i_reg_rd_en && !(i_reg_addr inside
    {8'h28, 8'h29, 8'h40, 8'h41}) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_dis_readback: assert property (s_rd(8'h40)
    |=> o_reg_rdata == $past(o_discharge_select[7:0]))
    else $error("discharge readback differs");
  chk_rail1_clear: assert property (i_rail_on[0]
    |=> o_discharge_select[1:0] == 2'h0) else $error("rail1 field kept");
  chk_aux2_clear: assert property (i_rail_on[7]
    |=> o_discharge_select[15:14] == 2'h0) else $error("aux2 field kept");
  // active lags select through reset, so skip that edge
  chk_active_code: assert property (!$past(i_sys_rst) |->
    o_discharge_active[7] == (o_discharge_select[15:14] != 2'h0))
    else $error("active flag disagrees with code");
endmodule : ldcr_chk
bind ldcr_top ldcr_chk u_chk (.*);
`default_nettype wire

/* testbench/ldcr_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ldcr_top_test;
  // ****
  // stimulus and checking
  // ****
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_rail_on = 8'h00;
  logic i_clk = 0, i_sys_rst = 1, i_reg_wr_en = 0, i_reg_rd_en = 0;
  logic i_aux2_on_request = 0, i_aux3_on_request = 0;
  logic i_sleep_select_pin_a = 0, i_sleep_select_pin_b = 0;
  logic i_aux2_sleep_use_pin_b = 0, i_aux3_sleep_use_pin_b = 1;
  logic [7:0] o_reg_rdata, o_discharge_active, seed = 8'h55;
  logic [15:0] o_discharge_select;
  logic o_aux2_enable, o_aux3_enable, o_aux2_sleep, o_aux3_sleep;
  logic o_aux2_codes_ignored, o_aux3_codes_ignored, rd_d = 0;
  logic [7:0] exp_q[$];
  int num_errors = 0, checks_done = 0;
  ldcr_top dut (.*);
  always #2 i_clk = ~i_clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wt
  task automatic wr(input logic [7:0] a, d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr_en = 1;
    @(negedge i_clk);
    i_reg_wr_en = 0;
  endtask : wr
  // expectation noted when the read is issued
  task automatic rd(input logic [7:0] a, e);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd_en = 1;
    exp_q.push_back(e);
    @(negedge i_clk);
    i_reg_rd_en = 0;
  endtask : rd
  always @(posedge i_clk) rd_d <= i_reg_rd_en;
  always @(negedge i_clk) if (rd_d) chk("rdata", exp_q.pop_front(), o_reg_rdata);
  task automatic stop_test;
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  initial begin
    #2000;
    num_errors++;
    stop_test();
  end
  initial begin
    wt(2);
    i_sys_rst = 0;
    {i_aux2_on_request, i_aux3_on_request} = 2'h3;
    {i_sleep_select_pin_a, i_sleep_select_pin_b} = 2'h3;
    rd(8'h28, 8'h0c);
    rd(8'h29, 8'h3c);
    rd(8'h40, 8'h55);
    rd(8'h41, 8'h55);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    chk("a3slp", 1, o_aux3_sleep);
    chk("a2slp", 0, o_aux2_sleep);
    chk("a3en", 0, o_aux3_enable);
    chk("a2en", 0, o_aux2_enable);
    wr(8'h28, 8'hff);
    wr(8'h29, 8'h31);
    i_sleep_select_pin_b = 0;
    wt(2);
    chk("a2en", 1, o_aux2_enable);
    chk("a2slp", 1, o_aux2_sleep);
    chk("a3slp", 0, o_aux3_sleep);
    chk("a3ign", 1, o_aux3_codes_ignored);
    chk("a2ign", 0, o_aux2_codes_ignored);
    rd(8'h28, 8'h3f);
    wr(8'h28, 8'h0c);
    wr(8'h29, 8'h3c);
    wt(1);
    chk("a2en", 0, o_aux2_enable);
    chk("a3en", 0, o_aux3_enable);
    for (int c = 0; c < 4; c++) begin
      wr(8'h40, {4{c[1:0]}});
      chk("act", {4{c != 0}}, o_discharge_active[3:0]);
      rd(8'h40, {4{c[1:0]}});
    end
    repeat (4) begin
      seed = lfsr(seed);
      wr(8'h41, seed);
      rd(8'h41, seed);
    end
    // aux2 and rail1 on: clearing must beat the write
    i_rail_on = 8'h81;
    wr(8'h40, 8'hff);
    rd(8'h40, 8'hfc);
    rd(8'h41, seed & 8'h3f);
    chk("act", 0, o_discharge_active[0]);
    i_rail_on = 8'h00;
    i_sys_rst = 1;
    wt(2);
    i_sys_rst = 0;
    rd(8'h29, 8'h3c);
    wt(2);
    stop_test();
  end
endmodule : ldcr_top_test
`default_nettype wire
